// [smpc_map.svh]
`ifndef SMPC_MAP_SVH
`define SMPC_MAP_SVH
`define SMPC_CLK_MHZ 100
`define SMPC_WORD_BITS 16
`define SMPC_WD_BIT 15
`define SMPC_WDRET_BIT 14
`define SMPC_ADDR_HI 11
`define SMPC_ADDR_LO 8
`define SMPC_ADDR_CFG 4'h0
`define SMPC_ADDR_DIRDIS 4'h1
`define SMPC_ADDR_DUTY0 4'h2
`define SMPC_ADDR_DLY01 4'h6
`define SMPC_ADDR_DLY23 4'h7
`define SMPC_ADDR_CAL 4'h8
`define SMPC_ADDR_PAGE 4'h9
`define SMPC_CFG_PWMEN 4
`define SMPC_CFG_CLKSEL 5
`define SMPC_CFG_OVDIS 6
`define SMPC_CFG_VDDEN 7
`define SMPC_PWM_STEPS 128
`define SMPC_CAL_SHIFT 7
`define SMPC_DELAY_SHIFT 4
`define SMPC_DUTY_FULL 7'h7F
`define SMPC_STARTUP_US 50
`define SMPC_STARTUP_CYC (`SMPC_STARTUP_US * `SMPC_CLK_MHZ)
`define SMPC_WD_TIMEOUT_US 10000
`define SMPC_WD_CYC (`SMPC_WD_TIMEOUT_US * `SMPC_CLK_MHZ)
`define SMPC_OSC_DEF_NS 78125
`define SMPC_OSC_DEF_CYC ((`SMPC_OSC_DEF_NS * `SMPC_CLK_MHZ) / 1000)
`define SMPC_IN0_MINPER_NS 19531
`define SMPC_IN0_MINPER_CYC ((`SMPC_IN0_MINPER_NS * `SMPC_CLK_MHZ + 999) / 1000)
`define SMPC_IN0_MAXPER_NS 78125
`define SMPC_IN0_MAXPER_CYC ((`SMPC_IN0_MAXPER_NS * `SMPC_CLK_MHZ) / 1000)
`define SMPC_CAL_MIN_US 7000
`define SMPC_CAL_MIN_CYC (`SMPC_CAL_MIN_US * `SMPC_CLK_MHZ)
`define SMPC_CAL_MAX_US 13000
`define SMPC_CAL_MAX_CYC (`SMPC_CAL_MAX_US * `SMPC_CLK_MHZ)
`endif

// [smpc_pkg.sv]
package smpc_pkg;
  typedef enum logic [1:0] {
    SMPC_SLEEP = 2'b00,
    SMPC_NORMAL = 2'b01,
    SMPC_FAILSAFE = 2'b11,
    SMPC_FAULT = 2'b10
  } smpc_mode_e;
  typedef logic [23:0] smpc_cnt_t;
endpackage : smpc_pkg

// [smpc_top.sv]
// Functional notes
// - wake is reset pin OR wake pin OR any direct-input active
// - fail: supply loss with detection enabled, or watchdog timeout with config pin open
// - fault: any channel current, thermal, short, low supply, or high supply with shutdown off
// - mode: sleep, normal, fail-safe or fault chosen from wake, fail, fault
// - sleep forces every configuration except the calibrated oscillator period and the calibration arm to zero and outputs off
// - normal sets mode flag; outputs follow direct/on bits or on bit with PWM wave
// - rearm is gated input OR on bit; its rising edge clears latched faults
// - with PWM enabled the PWM drives outputs and other direct inputs are ignored
// - PWM clock is 128 times output rate, from input zero or internal oscillator
// - on bit zero gives off; code n gives (n+1)/128 duty; all ones fully on
// - three-bit delay shifts each channel by code times 16 PWM clocks
// - external PWM clock monitored; out of range drops PWM, on bits rule, flag set
// - after calibration word, chip-select low time divided by 128 sets oscillator period
// - calibration pulse outside window is ignored, previous or default period kept
// - watchdog starts on rising wake, input or reset edges; grounded config pin disables
// - timeout or supply loss enters fail-safe until return bit written or config pin grounded, with supply good
// - fail-safe: outputs follow inputs, settings default, protections on except high-supply output shutdown, mode flag zero
// - return bit leaves fail-safe; both transitions clear latched faults
// - fault pin asserts on faults other than high supply, which it flags only with shutdown on; latched ones need a rearm toggle to release
// - fault flags held until the next valid transfer of their page reads and clears them
// - reset pin clears registers; features usable 50 us after wake
// - 16-bit words MSB first, sample on sclk fall, shift on rise, commit on select rise
`timescale 1ns/1ps
`include "smpc_map.svh"
module smpc_top
  import smpc_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = `SMPC_STARTUP_CYC,
  parameter int unsigned WD_CYC = `SMPC_WD_CYC,
  parameter int unsigned OSC_DEF_CYC = `SMPC_OSC_DEF_CYC,
  parameter int unsigned IN0_MIN_CYC = `SMPC_IN0_MINPER_CYC,
  parameter int unsigned IN0_MAX_CYC = `SMPC_IN0_MAXPER_CYC,
  parameter int unsigned CAL_MIN_CYC = `SMPC_CAL_MIN_CYC,
  parameter int unsigned CAL_MAX_CYC = `SMPC_CAL_MAX_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic reset_n,
  input wire logic wakePin,
  input wire logic [3:0] directIn,
  input wire logic failsafe_config_pin,
  input wire logic [3:0] current_limit_fault,
  input wire logic [3:0] thermal_fault,
  input wire logic [3:0] short_circuit_fault,
  input wire logic supply_low_fault,
  input wire logic supply_high_fault,
  input wire logic logicSupplyLoss,
  input wire logic [3:0] openLoadOn,
  output logic [3:0] hsOut,
  output logic fault_pin_n_out,
  output logic fault_pin_n_oe,
  output logic normal_mode_flag,
  output logic clockFailFlag
);
  // link side: shift in on falling sclk, shift out on rising sclk
  logic spiClr;
  logic [4:0] rxCnt_r;
  logic [14:0] rxShift_r;
  logic [15:0] rxWord_r;
  logic rxTog_r;
  logic [3:0] txIdx_r;
  logic [15:0] statusHold_r;
  assign spiClr = chip_select_n | ~rst_n;
  always_ff @(negedge sclk or posedge spiClr)
  begin
    if (spiClr)
    begin
      rxCnt_r <= 5'h00;
      rxShift_r <= 15'h0000;
    end
    else
    begin
      if (rxCnt_r != 5'h10)
        rxCnt_r <= rxCnt_r + 5'h01;
      rxShift_r <= {rxShift_r[13:0], serialIn};
    end
  end
  always_ff @(negedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxWord_r <= 16'h0000;
      rxTog_r <= 1'b0;
    end
    else if (rxCnt_r == 5'h0F)
    begin
      rxWord_r <= {rxShift_r, serialIn};
      rxTog_r <= ~rxTog_r;
    end
  end
  always_ff @(posedge sclk or posedge spiClr)
  begin
    if (spiClr)
      txIdx_r <= 4'h0;
    else if (rxCnt_r != 5'h00)
      txIdx_r <= txIdx_r + 4'h1;
  end
  // snapshot is frozen while selected, so the link domain reads it safely
  assign serialOut = statusHold_r[4'hF - txIdx_r];

  // synchronisers for every pin except rst_n, sclk and serialIn, and for the link toggle
  localparam int unsigned SW = 28;
  logic [SW-1:0] syncA_r;
  logic [SW-1:0] syncB_r;
  logic [SW-1:0] syncPrev_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_r <= '0;
      syncB_r <= '0;
      syncPrev_r <= '0;
    end
    else
    begin
      syncA_r <= {rxTog_r, chip_select_n, reset_n, wakePin, failsafe_config_pin, directIn,
                  current_limit_fault, thermal_fault, short_circuit_fault,
                  supply_low_fault, supply_high_fault, logicSupplyLoss, openLoadOn};
      syncB_r <= syncA_r;
      syncPrev_r <= syncB_r;
    end
  end
  logic tgS, csS, csPrev, rstPinS, wakeS, fsiS, uvS, ovS, vddLossS;
  logic [3:0] dinS, dinPrev, ocS, otS, scS, olS;
  assign tgS = syncB_r[27];
  assign csS = syncB_r[26];
  assign csPrev = syncPrev_r[26];
  assign rstPinS = syncB_r[25];
  assign wakeS = syncB_r[24];
  assign fsiS = syncB_r[23];
  assign dinS = syncB_r[22:19];
  assign dinPrev = syncPrev_r[22:19];
  assign ocS = syncB_r[18:15];
  assign otS = syncB_r[14:11];
  assign scS = syncB_r[10:7];
  assign uvS = syncB_r[6];
  assign ovS = syncB_r[5];
  assign vddLossS = syncB_r[4];
  assign olS = syncB_r[3:0];

  logic csRise, csFall, tgSeen_r, wordPend_r, xferDone, wordNew;
  assign csRise = csS & ~csPrev;
  assign csFall = ~csS & csPrev;
  assign wordNew = tgS ^ tgSeen_r;
  assign xferDone = csRise & (wordPend_r | wordNew);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgSeen_r <= 1'b0;
      wordPend_r <= 1'b0;
    end
    else
    begin
      tgSeen_r <= tgS;
      wordPend_r <= (wordPend_r | wordNew) & ~csRise;
    end
  end

  // mode selection
  smpc_mode_e mode_r, modeNxt;
  logic wakeUp, faultCond, failLatch_r, ready_r, cfgWr, modeSwap;
  logic [3:0] chFault_r, rearmPrev_r, rearm, rearmRise;
  logic uvLatch_r;
  smpc_cnt_t readyCnt_r;
  assign wakeUp = rstPinS | wakeS | (|dinS);
  logic [3:0] onBits_r, dirDis_r;
  logic pwmEn_r, clkSel_r, ovDis_r, vddEn_r, calArm_r, page_r;
  logic [6:0] duty_r [4];
  logic [2:0] delay_r [4];
  assign faultCond = (|chFault_r) | (|otS) | uvLatch_r | (ovS & ovDis_r);
  always_comb
  begin
    if (!wakeUp)
      modeNxt = SMPC_SLEEP;
    else if (faultCond)
      modeNxt = SMPC_FAULT;
    else if (failLatch_r)
      modeNxt = SMPC_FAILSAFE;
    else
      modeNxt = SMPC_NORMAL;
  end
  assign modeSwap = (mode_r == SMPC_NORMAL && modeNxt == SMPC_FAILSAFE) ||
                    (mode_r == SMPC_FAILSAFE && modeNxt == SMPC_NORMAL);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= SMPC_SLEEP;
    else
      mode_r <= modeNxt;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      readyCnt_r <= '0;
    else if (!wakeUp)
      readyCnt_r <= '0;
    else if (readyCnt_r != smpc_cnt_t'(STARTUP_CYC))
      readyCnt_r <= readyCnt_r + 24'h000001;
  end
  assign ready_r = readyCnt_r == smpc_cnt_t'(STARTUP_CYC);
  assign cfgWr = xferDone & ready_r & (mode_r == SMPC_NORMAL || mode_r == SMPC_FAULT);

  // watchdog
  logic [5:0] wakeVec, wakeVecPrev;
  logic wdArmed_r, wdLast_r, wdKick, wdTimeout;
  smpc_cnt_t wdCnt_r;
  assign wakeVec = {rstPinS, wakeS, dinS};
  assign wakeVecPrev = {syncPrev_r[25], syncPrev_r[24], dinPrev};
  assign wdKick = xferDone & (rxWord_r[`SMPC_WD_BIT] != wdLast_r);
  assign wdTimeout = wdArmed_r & fsiS & (wdCnt_r == smpc_cnt_t'(WD_CYC));
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdArmed_r <= 1'b0;
      wdLast_r <= 1'b0;
      wdCnt_r <= '0;
    end
    else
    begin
      if (!fsiS || !wakeUp)
        wdArmed_r <= 1'b0;
      else if (|(wakeVec & ~wakeVecPrev))
        wdArmed_r <= 1'b1;
      if (xferDone)
        wdLast_r <= rxWord_r[`SMPC_WD_BIT];
      if (!wdArmed_r || wdKick || failLatch_r)
        wdCnt_r <= '0;
      else if (!wdTimeout)
        wdCnt_r <= wdCnt_r + 24'h000001;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      failLatch_r <= 1'b0;
    else if (!wakeUp)
      failLatch_r <= 1'b0;
    else if (wdTimeout || (vddLossS && vddEn_r))
      failLatch_r <= 1'b1;
    else if ((xferDone && rxWord_r[`SMPC_WDRET_BIT] && !vddLossS) || (!fsiS && !vddLossS))
      failLatch_r <= 1'b0;
  end

  // configuration, cleared in sleep, fail-safe and while the reset pin is low
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      onBits_r <= 4'h0;
      dirDis_r <= 4'h0;
      pwmEn_r <= 1'b0;
      clkSel_r <= 1'b0;
      ovDis_r <= 1'b0;
      vddEn_r <= 1'b0;
      page_r <= 1'b0;
      duty_r <= '{default: 7'h00};
      delay_r <= '{default: 3'h0};
    end
    else if (mode_r == SMPC_SLEEP || mode_r == SMPC_FAILSAFE || !rstPinS)
    begin
      onBits_r <= 4'h0;
      dirDis_r <= 4'h0;
      pwmEn_r <= 1'b0;
      clkSel_r <= 1'b0;
      ovDis_r <= 1'b0;
      vddEn_r <= 1'b0;
      page_r <= 1'b0;
      duty_r <= '{default: 7'h00};
      delay_r <= '{default: 3'h0};
    end
    else if (cfgWr)
    begin
      case (rxWord_r[`SMPC_ADDR_HI:`SMPC_ADDR_LO])
        `SMPC_ADDR_CFG:
        begin
          onBits_r <= rxWord_r[3:0];
          pwmEn_r <= rxWord_r[`SMPC_CFG_PWMEN];
          clkSel_r <= rxWord_r[`SMPC_CFG_CLKSEL];
          ovDis_r <= rxWord_r[`SMPC_CFG_OVDIS];
          vddEn_r <= rxWord_r[`SMPC_CFG_VDDEN];
        end
        `SMPC_ADDR_DIRDIS: dirDis_r <= rxWord_r[3:0];
        `SMPC_ADDR_DLY01: {delay_r[1], delay_r[0]} <= rxWord_r[5:0];
        `SMPC_ADDR_DLY23: {delay_r[3], delay_r[2]} <= rxWord_r[5:0];
        `SMPC_ADDR_PAGE: page_r <= rxWord_r[0];
        default:
        begin
          if (rxWord_r[11:8] >= `SMPC_ADDR_DUTY0 && rxWord_r[11:8] <= (`SMPC_ADDR_DUTY0 + 4'h3))
            duty_r[rxWord_r[9:8] - 2'h2] <= rxWord_r[6:0];
        end
      endcase
    end
  end

  // fault latching and rearm
  assign rearm = ((dinS & ~dirDis_r) & {4{~pwmEn_r}}) | onBits_r;
  assign rearmRise = rearm & ~rearmPrev_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rearmPrev_r <= 4'h0;
      chFault_r <= 4'h0;
      uvLatch_r <= 1'b0;
    end
    else
    begin
      rearmPrev_r <= rearm;
      if (mode_r == SMPC_SLEEP || modeSwap)
      begin
        chFault_r <= 4'h0;
        uvLatch_r <= 1'b0;
      end
      else
      begin
        chFault_r <= (chFault_r & ~rearmRise) | ocS | (otS & rearm) | scS;
        uvLatch_r <= (uvLatch_r & ~(|rearmRise)) | uvS;
      end
    end
  end

  // PWM clocking: external input zero or calibrated internal oscillator
  smpc_cnt_t oscPer_r, oscCnt_r, monCnt_r, calCnt_r;
  logic calRun_r, clkFail_r, pwmTick, in0Rise, pwmLive;
  logic [6:0] pwmCnt_r;
  assign in0Rise = dinS[0] & ~dinPrev[0];
  assign pwmTick = clkSel_r ? (oscCnt_r == '0) : in0Rise;
  assign pwmLive = pwmEn_r & (clkSel_r | ~clkFail_r);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      oscCnt_r <= '0;
    else if (oscCnt_r == '0)
      oscCnt_r <= oscPer_r - 24'h000001;
    else
      oscCnt_r <= oscCnt_r - 24'h000001;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oscPer_r <= smpc_cnt_t'(OSC_DEF_CYC);
      calArm_r <= 1'b0;
      calRun_r <= 1'b0;
      calCnt_r <= '0;
    end
    else
    begin
      if (calRun_r && calCnt_r != '1)
        calCnt_r <= calCnt_r + 24'h000001;
      if (cfgWr && rxWord_r[`SMPC_ADDR_HI:`SMPC_ADDR_LO] == `SMPC_ADDR_CAL)
        calArm_r <= 1'b1;
      else if (csFall && calArm_r)
      begin
        calRun_r <= 1'b1;
        calCnt_r <= '0;
      end
      else if (csRise && calRun_r)
      begin
        calRun_r <= 1'b0;
        calArm_r <= 1'b0;
        if (calCnt_r >= smpc_cnt_t'(CAL_MIN_CYC) && calCnt_r <= smpc_cnt_t'(CAL_MAX_CYC))
          oscPer_r <= calCnt_r >> `SMPC_CAL_SHIFT;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      monCnt_r <= '0;
      clkFail_r <= 1'b0;
    end
    else if (!pwmEn_r || clkSel_r)
    begin
      monCnt_r <= '0;
      clkFail_r <= 1'b0;
    end
    else if (in0Rise)
    begin
      monCnt_r <= '0;
      clkFail_r <= (monCnt_r < smpc_cnt_t'(IN0_MIN_CYC)) || (monCnt_r > smpc_cnt_t'(IN0_MAX_CYC));
    end
    else if (monCnt_r > smpc_cnt_t'(IN0_MAX_CYC))
      clkFail_r <= 1'b1;
    else
      monCnt_r <= monCnt_r + 24'h000001;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pwmCnt_r <= 7'h00;
    else if (!pwmLive)
      pwmCnt_r <= 7'h00;
    else if (pwmTick)
      pwmCnt_r <= pwmCnt_r + 7'h01;
  end

  // output drive
  logic [3:0] wave, cmd, hsNxt;
  logic [6:0] phase [4];
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      phase[i] = pwmCnt_r - {delay_r[i], 4'h0};
      wave[i] = (duty_r[i] == `SMPC_DUTY_FULL) || (phase[i] <= duty_r[i]);
    end
    if (pwmLive)
      cmd = onBits_r & wave;
    else if (pwmEn_r)
      cmd = onBits_r;
    else
      cmd = (dinS & ~dirDis_r) | onBits_r;
    case (mode_r)
      SMPC_SLEEP: hsNxt = 4'h0;
      SMPC_FAILSAFE: hsNxt = dinS & ~chFault_r;
      SMPC_NORMAL, SMPC_FAULT:
        hsNxt = cmd & ~chFault_r & {4{~uvLatch_r & ~(ovS & ~ovDis_r)}};
      default: hsNxt = 4'h0;
    endcase
  end

  // sticky diagnostic reports, cleared when shown in a completed transfer
  logic [3:0] ocRep_r, otRep_r, scRep_r, olRep_r;
  logic uvRep_r, ovRep_r, rdP0, rdP1;
  assign rdP0 = xferDone & ~statusHold_r[15] & ~page_r;
  assign rdP1 = xferDone & page_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ocRep_r <= 4'h0;
      otRep_r <= 4'h0;
      scRep_r <= 4'h0;
      olRep_r <= 4'h0;
      uvRep_r <= 1'b0;
      ovRep_r <= 1'b0;
    end
    else
    begin
      ocRep_r <= (ocRep_r & ~({4{rdP0}} & statusHold_r[11:8])) | ocS;
      otRep_r <= (otRep_r & ~({4{rdP0}} & statusHold_r[7:4])) | otS;
      scRep_r <= (scRep_r & ~({4{rdP0}} & statusHold_r[3:0])) | scS;
      uvRep_r <= (uvRep_r & ~(rdP0 & statusHold_r[13])) | uvS;
      ovRep_r <= (ovRep_r & ~(rdP0 & statusHold_r[12])) | ovS;
      olRep_r <= (olRep_r & ~({4{rdP1}} & statusHold_r[3:0])) | olS;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      statusHold_r <= 16'h0000;
      serialOutEn <= 1'b0;
      hsOut <= 4'h0;
      fault_pin_n_out <= 1'b0;
      fault_pin_n_oe <= 1'b0;
      normal_mode_flag <= 1'b0;
      clockFailFlag <= 1'b0;
    end
    else
    begin
      if (csS)
        statusHold_r <= page_r ? {12'h000, olRep_r} :
          {1'b0, clkFail_r, uvRep_r, ovRep_r, ocRep_r, otRep_r, scRep_r};
      serialOutEn <= ~csS;
      hsOut <= hsNxt;
      fault_pin_n_oe <= (mode_r != SMPC_SLEEP) &
        ((|chFault_r) | uvLatch_r | (ovS & ~ovDis_r) | (|otS));
      normal_mode_flag <= modeNxt == SMPC_NORMAL;
      clockFailFlag <= clkFail_r;
    end
  end
endmodule : smpc_top

// [smpc_chk_asserts.sv]
`timescale 1ns/1ps
module smpc_chk
  import smpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic reset_n,
  input wire logic wakePin,
  input wire logic [3:0] directIn,
  input wire logic [3:0] thermal_fault,
  input wire logic supply_low_fault,
  input wire logic serialOutEn,
  input wire logic [3:0] hsOut,
  input wire logic fault_pin_n_out,
  input wire logic fault_pin_n_oe,
  input wire logic normal_mode_flag,
  input wire logic clockFailFlag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic asleep;
  logic hot;
  assign asleep = !reset_n && !wakePin && directIn == 4'h0;
  assign hot = reset_n && thermal_fault != 4'h0;

  property p_sleep_off;
    asleep [*6] |-> hsOut == 4'h0 && !normal_mode_flag;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("outputs active while asleep");
  property p_sleep_cfg;
    asleep [*6] |-> !clockFailFlag;
  endproperty
  a_sleep_cfg: assert property (p_sleep_cfg)
    else $error("clock failure flagged while asleep");
  property p_hot_mode;
    hot [*6] |-> !normal_mode_flag;
  endproperty
  a_hot_mode: assert property (p_hot_mode)
    else $error("normal flag kept during thermal fault");
  property p_hot_pin;
    hot [*6] |-> fault_pin_n_oe;
  endproperty
  a_hot_pin: assert property (p_hot_pin)
    else $error("fault pin idle during thermal fault");
  property p_low_pin;
    $rose(supply_low_fault) && reset_n ##1 (reset_n && supply_low_fault) [*5] |-> fault_pin_n_oe;
  endproperty
  a_low_pin: assert property (p_low_pin)
    else $error("fault pin idle during low supply");
  property p_open_drain;
    fault_pin_n_oe |-> fault_pin_n_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("fault pin driven high");
  property p_so_off;
    chip_select_n [*5] |-> !serialOutEn;
  endproperty
  a_so_off: assert property (p_so_off)
    else $error("serial output enabled while deselected");
  property p_so_on;
    $fell(chip_select_n) ##1 !chip_select_n [*3] |-> ##[0:2] serialOutEn;
  endproperty
  a_so_on: assert property (p_so_on)
    else $error("serial output not enabled while selected");
endmodule : smpc_chk

bind smpc_top smpc_chk u_chk (.ref_clk, .rst_n, .chip_select_n, .reset_n, .wakePin,
  .directIn, .thermal_fault, .supply_low_fault, .serialOutEn, .hsOut, .fault_pin_n_out,
  .fault_pin_n_oe, .normal_mode_flag, .clockFailFlag);

// [smpc_host.sv]
`timescale 1ns/1ps
module smpc_host
  import smpc_pkg::*;
(
  output logic sclk,
  output logic chip_select_n,
  output logic serialIn,
  input wire logic serialOut
);
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serialIn = 1'b0;
  end
  // link clock 32 ns, only inside a frame; data line back to its pull-down level after
  task automatic xfer(input logic [15:0] txWord, output logic [15:0] rxWord);
    #2;
    chip_select_n = 1'b0;
    #48;
    for (int i = 15; i >= 0; i--)
    begin
      sclk = 1'b1;
      serialIn = txWord[i];
      #16;
      sclk = 1'b0;
      rxWord[i] = serialOut;
      #16;
    end
    serialIn = 1'b0;
    chip_select_n = 1'b1;
    #60;
  endtask : xfer
  task automatic pulse(input int unsigned lowNs);
    #2;
    chip_select_n = 1'b0;
    #(lowNs);
    chip_select_n = 1'b1;
    #60;
  endtask : pulse
endmodule : smpc_host

// [smpc_top_bench.sv]
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); \
    end \
  end
module smpc_top_bench
  import smpc_pkg::*;
;
  logic ref_clk, rst_n, sclk, chip_select_n, serialIn, serialOut, serialOutEn;
  logic reset_n, wakePin, failsafe_config_pin, supply_low_fault, wdTog;
  logic supply_high_fault, logicSupplyLoss;
  logic [3:0] current_limit_fault, short_circuit_fault;
  logic fault_pin_n_out, fault_pin_n_oe, normal_mode_flag, clockFailFlag;
  logic [3:0] directIn, thermal_fault, openLoadOn, hsOut;
  logic [15:0] rdw;
  int failures, checked, h;

  smpc_top #(.STARTUP_CYC(20), .WD_CYC(200), .OSC_DEF_CYC(4), .IN0_MIN_CYC(2),
    .IN0_MAX_CYC(40), .CAL_MIN_CYC(512), .CAL_MAX_CYC(2048)) i_dut (
    .ref_clk, .rst_n, .sclk, .chip_select_n, .serialIn, .serialOut, .serialOutEn,
    .reset_n, .wakePin, .directIn, .failsafe_config_pin,
    .current_limit_fault, .thermal_fault, .short_circuit_fault,
    .supply_low_fault, .supply_high_fault, .logicSupplyLoss,
    .openLoadOn, .hsOut, .fault_pin_n_out, .fault_pin_n_oe, .normal_mode_flag,
    .clockFailFlag);
  smpc_host i_host (.sclk, .chip_select_n, .serialIn, .serialOut);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // one cycle of a bounded wait; running out ends the run
  task automatic st(inout int n);
    @(posedge ref_clk);
    n++;
    if (n > 3000)
    begin
      failures++;
      conclude();
    end
  endtask : st
  task automatic xw(input logic rb, input logic [3:0] a, input logic [7:0] d);
    wdTog = ~wdTog;
    i_host.xfer({wdTog, rb, 2'b00, a, d}, rdw);
    cyc(6);
  endtask : xw
  task automatic waitNm(input logic v);
    int n;
    n = 0;
    while (normal_mode_flag !== v)
      st(n);
  endtask : waitNm
  task automatic hiCnt(input int len, output int hc);
    hc = 0;
    repeat (len)
    begin
      cyc(1);
      hc += int'(hsOut[0] === 1'b1);
    end
  endtask : hiCnt
  // width of the next high pulse on channel 0
  task automatic pw(output int w);
    int n;
    n = 0;
    w = 0;
    while (hsOut[0] !== 1'b0)
      st(n);
    while (hsOut[0] !== 1'b1)
      st(n);
    while (hsOut[0] === 1'b1)
      st(w);
  endtask : pw
  function automatic bit near(input int a, input int e);
    return a >= e - 2 && a <= e + 2;
  endfunction : near

  task automatic t_wake();
    cyc(8);
    `CHK(hsOut, 4'h0)
    `CHK(fault_pin_n_oe, 1'b0)
    directIn <= 4'h6;
    waitNm(1'b1);
    cyc(4);
    `CHK(hsOut, 4'h6)
    directIn <= 4'h0;
    reset_n <= 1'b1;
    cyc(40);
    `CHK(normal_mode_flag, 1'b1)
    xw(1'b0, 4'h0, 8'h0A);
    `CHK(hsOut, 4'hA)
    directIn <= 4'h5;
    cyc(6);
    `CHK(hsOut, 4'hF)
    xw(1'b0, 4'h1, 8'h05);
    `CHK(hsOut, 4'hA)
    reset_n <= 1'b0;
    cyc(8);
    `CHK(hsOut, 4'h5)
    reset_n <= 1'b1;
    directIn <= 4'h0;
    cyc(40);
    $display("wake and direct control done");
  endtask : t_wake

  task automatic t_fault();
    xw(1'b0, 4'h0, 8'h0A);
    thermal_fault <= 4'h1;
    cyc(8);
    `CHK(normal_mode_flag, 1'b0)
    `CHK(fault_pin_n_oe, 1'b1)
    thermal_fault <= 4'h0;
    cyc(8);
    `CHK(fault_pin_n_oe, 1'b0)
    xw(1'b0, 4'h9, 8'h00);
    `CHK(rdw[4], 1'b1)
    xw(1'b0, 4'h9, 8'h00);
    `CHK(rdw[4], 1'b0)
    openLoadOn <= 4'h2;
    xw(1'b0, 4'h9, 8'h01);
    xw(1'b0, 4'h9, 8'h01);
    `CHK(rdw[3:0], 4'h2)
    `CHK(fault_pin_n_oe, 1'b0)
    `CHK(hsOut, 4'hA)
    openLoadOn <= 4'h0;
    xw(1'b0, 4'h9, 8'h00);
    supply_low_fault <= 1'b1;
    cyc(8);
    `CHK(fault_pin_n_oe, 1'b1)
    `CHK(hsOut, 4'h0)
    supply_low_fault <= 1'b0;
    cyc(8);
    `CHK(fault_pin_n_oe, 1'b1)
    xw(1'b0, 4'h0, 8'h00);
    xw(1'b0, 4'h0, 8'h0A);
    xw(1'b0, 4'h9, 8'h00);
    `CHK(fault_pin_n_oe, 1'b0)
    $display("fault reporting done");
  endtask : t_fault

  task automatic t_prot();
    current_limit_fault <= 4'h2;
    cyc(8);
    current_limit_fault <= 4'h0;
    cyc(8);
    `CHK(hsOut, 4'h8)
    `CHK(fault_pin_n_oe, 1'b1)
    xw(1'b0, 4'h0, 8'h08);
    `CHK(rdw[11:8], 4'h2)
    xw(1'b0, 4'h0, 8'h0A);
    `CHK(hsOut, 4'hA)
    `CHK(fault_pin_n_oe, 1'b0)
    short_circuit_fault <= 4'h8;
    cyc(8);
    `CHK(normal_mode_flag, 1'b0)
    `CHK(hsOut, 4'h2)
    short_circuit_fault <= 4'h0;
    xw(1'b0, 4'h0, 8'h02);
    `CHK(rdw[3:0], 4'h8)
    `CHK(fault_pin_n_oe, 1'b1)
    xw(1'b0, 4'h0, 8'h0A);
    `CHK(fault_pin_n_oe, 1'b0)
    supply_high_fault <= 1'b1;
    cyc(8);
    `CHK(hsOut, 4'h0)
    `CHK(normal_mode_flag, 1'b1)
    xw(1'b0, 4'h0, 8'h4A);
    `CHK(hsOut, 4'hA)
    `CHK(normal_mode_flag, 1'b0)
    supply_high_fault <= 1'b0;
    xw(1'b0, 4'h0, 8'h8A);
    failsafe_config_pin <= 1'b1;
    logicSupplyLoss <= 1'b1;
    cyc(8);
    `CHK(normal_mode_flag, 1'b0)
    `CHK(hsOut, 4'h0)
    logicSupplyLoss <= 1'b0;
    cyc(8);
    `CHK(normal_mode_flag, 1'b0)
    xw(1'b1, 4'h0, 8'h00);
    `CHK(normal_mode_flag, 1'b1)
    failsafe_config_pin <= 1'b0;
    $display("protection done");
  endtask : t_prot

  task automatic t_pwm();
    xw(1'b0, 4'h2, 8'h3F);
    xw(1'b0, 4'h3, 8'h3F);
    xw(1'b0, 4'h6, 8'h08);
    xw(1'b0, 4'h0, 8'h33);
    directIn <= 4'hE;
    hiCnt(1024, h);
    `CHK(near(h, 512), 1'b1)
    `CHK(hsOut[3:2], 2'h0)
    directIn <= 4'h0;
    pw(h);
    h = 0;
    while (hsOut[1] !== 1'b0)
      st(h);
    `CHK(near(h, 64), 1'b1)
    xw(1'b0, 4'h2, 8'h7F);
    hiCnt(1024, h);
    `CHK(h, 1024)
    xw(1'b0, 4'h2, 8'h00);
    pw(h);
    pw(h);
    `CHK(near(h, 4), 1'b1)
    xw(1'b0, 4'h8, 8'h00);
    i_host.pulse(10880);
    cyc(1);
    pw(h);
    pw(h);
    `CHK(near(h, 8), 1'b1)
    xw(1'b0, 4'h8, 8'h00);
    i_host.pulse(3000);
    cyc(1);
    pw(h);
    pw(h);
    `CHK(near(h, 8), 1'b1)
    xw(1'b0, 4'h0, 8'h11);
    cyc(100);
    `CHK(clockFailFlag, 1'b1)
    `CHK(hsOut[0], 1'b1)
    repeat (40)
    begin
      directIn[0] <= ~directIn[0];
      cyc(5);
    end
    `CHK(clockFailFlag, 1'b0)
    directIn <= 4'h0;
    $display("pwm done");
  endtask : t_pwm

  task automatic t_wd();
    xw(1'b0, 4'h0, 8'h0A);
    failsafe_config_pin <= 1'b1;
    cyc(2);
    wakePin <= 1'b1;
    repeat (4) xw(1'b0, 4'h9, 8'h00);
    `CHK(normal_mode_flag, 1'b1)
    waitNm(1'b0);
    `CHK(normal_mode_flag, 1'b0)
    directIn <= 4'h5;
    cyc(6);
    `CHK(hsOut, 4'h5)
    xw(1'b1, 4'h0, 8'h0F);
    waitNm(1'b1);
    cyc(4);
    `CHK(hsOut, 4'h5)
    failsafe_config_pin <= 1'b0;
    directIn <= 4'h0;
    $display("watchdog done");
  endtask : t_wd

  initial
  begin
    failures = 0;
    checked = 0;
    wdTog = 1'b0;
    rst_n = 1'b0;
    reset_n = 1'b0;
    wakePin = 1'b0;
    directIn = 4'h0;
    failsafe_config_pin = 1'b0;
    thermal_fault = 4'h0;
    supply_low_fault = 1'b0;
    supply_high_fault = 1'b0;
    logicSupplyLoss = 1'b0;
    current_limit_fault = 4'h0;
    short_circuit_fault = 4'h0;
    openLoadOn = 4'h0;
    cyc(3);
    rst_n <= 1'b1;
    t_wake();
    t_fault();
    t_prot();
    t_pwm();
    t_wd();
    conclude();
  end
endmodule : smpc_top_bench
